// >>> verilog/hid_decode.sv
`timescale 1ns/1ns
module hid_decode (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic sof_pulse,
    input wire logic [4:0] frame_num,
    input wire logic [2:0] uframe,
    output logic tok_valid,
    output logic [1:0] tok_pid,
    output logic [6:0] tok_faddr,
    output logic [3:0] tok_endpoint,
    output logic tok_split,
    output logic [15:0] tok_ptr,
    output logic [10:0] tok_maxpkt,
    output logic tok_toggle,
    input wire logic res_valid,
    input wire hid_pkg::hid_res_e res_code,
    input wire logic [14:0] res_bytes
);
    import hid_pkg::*;

    typedef struct packed {
        hid_state_e st;
        logic [31:0] dw0;
        logic [31:0] dw1;
        logic [31:0] dw2;
        logic [31:0] dw3;
        logic [31:0] dw4;
        logic [1:0] pkts;
        // Latched microframe, whose mask bit is cleared when done
        logic [2:0] uf;
        logic [31:0] rdata;
    } hid_state_s;

    hid_state_s s;
    hid_state_s next_s;
    logic due;
    logic eligible;
    logic wr0;
    logic wr3;
    logic wr4;
    logic [15:0] sum;
    logic complete;
    logic [1:0] mult;

    hid_poll_match #(
        .FSEL_W(5)
    ) u_poll (
        .frame_sel(s.dw2[HID_FSEL_HI:HID_FSEL_LO]),
        .frame_num(frame_num),
        .schedule_mask(s.dw4[HID_MASK_HI:HID_MASK_LO]),
        .uframe(uframe),
        .due(due)
    );

    // Write decodes let a software set win over the controller clears after an ACK
    assign wr0 = reg_wr && reg_addr == HID_ADDR_DW0;
    assign wr3 = reg_wr && reg_addr == HID_ADDR_DW3;
    assign wr4 = reg_wr && reg_addr == HID_ADDR_DW4;
    assign mult = s.dw0[HID_MULT_HI:HID_MULT_LO];

    // Stopped or disarmed descriptors are never touched
    assign eligible = s.dw0[HID_ARMED_BIT] && s.dw3[HID_RUN_BIT]
        && !s.dw3[HID_STOP_BIT];

    assign sum = {1'b0, s.dw3[HID_DONE_HI:HID_DONE_LO]} + {1'b0, res_bytes};
    // Short packet or total reached ends the whole descriptor
    assign complete = (sum >= {1'b0, s.dw0[HID_TOTAL_HI:HID_TOTAL_LO]})
        || (res_bytes < {4'h0, s.dw0[HID_MAXPKT_HI:HID_MAXPKT_LO]});

    // Mult of zero is undefined; issuing nothing is the safe reading
    assign tok_valid = s.st == HID_ST_ISSUE && eligible && s.pkts < mult;
    assign tok_pid = s.dw1[HID_TOKEN_HI:HID_TOKEN_LO];
    assign tok_faddr = s.dw1[HID_FADDR_HI:HID_FADDR_LO];
    assign tok_endpoint = {s.dw1[HID_EPU_HI:HID_EPU_LO], s.dw0[HID_EP0_BIT]};
    assign tok_split = s.dw1[HID_SPLIT_BIT];
    assign tok_ptr = s.dw2[HID_PTR_HI:HID_PTR_LO];
    assign tok_maxpkt = s.dw0[HID_MAXPKT_HI:HID_MAXPKT_LO];
    assign tok_toggle = s.dw3[HID_TOGGLE_BIT];
    assign reg_rdata = s.rdata;

    always_comb
    begin
        next_s = s;
        next_s.rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                HID_ADDR_DW0: next_s.rdata = s.dw0;
                HID_ADDR_DW1: next_s.rdata = s.dw1;
                HID_ADDR_DW2: next_s.rdata = s.dw2;
                HID_ADDR_DW3: next_s.rdata = s.dw3;
                HID_ADDR_DW4: next_s.rdata = s.dw4;
                HID_ADDR_STAT: next_s.rdata = {25'h0, s.uf, s.pkts, s.st};
                default: next_s.rdata = '0;
            endcase
        end
        // Software first; controller updates below override its fields, except an ACK clear of a bit that software sets in the same cycle
        if (reg_wr)
        begin
            case (reg_addr)
                HID_ADDR_DW0: next_s.dw0 = reg_wdata & HID_DW0_WMASK;
                HID_ADDR_DW1: next_s.dw1 = reg_wdata & HID_DW1_WMASK;
                HID_ADDR_DW2: next_s.dw2 = reg_wdata & HID_DW2_WMASK;
                HID_ADDR_DW3: next_s.dw3 = reg_wdata & HID_DW3_WMASK;
                HID_ADDR_DW4: next_s.dw4 = reg_wdata & HID_DW4_WMASK;
                default: next_s = next_s;
            endcase
        end
        case (s.st)
            HID_ST_IDLE:
            begin
                if (sof_pulse && eligible && due)
                begin
                    next_s.pkts = '0;
                    next_s.uf = uframe;
                    next_s.st = HID_ST_ISSUE;
                end
            end
            HID_ST_ISSUE:
            begin
                if (tok_valid)
                begin
                    next_s.pkts = s.pkts + 2'h1;
                    next_s.st = HID_ST_WAIT;
                end
                else
                begin
                    next_s.st = HID_ST_IDLE;
                end
            end
            HID_ST_WAIT:
            begin
                if (res_valid)
                begin
                    next_s.st = HID_ST_IDLE;
                    case (res_code)
                        HID_RES_ACK:
                        begin
                            next_s.dw3[HID_TOGGLE_BIT] = !s.dw3[HID_TOGGLE_BIT];
                            // Intermediate total kept between packets
                            next_s.dw3[HID_DONE_HI:HID_DONE_LO] = sum[14:0];
                            if (complete)
                            begin
                                // A set by software in this cycle wins
                                if (!(wr0 && reg_wdata[HID_ARMED_BIT]))
                                    next_s.dw0[HID_ARMED_BIT] = 1'b0;
                                if (!(wr3 && reg_wdata[HID_RUN_BIT]))
                                    next_s.dw3[HID_RUN_BIT] = 1'b0;
                                if (!(wr4 && reg_wdata[s.uf]))
                                    next_s.dw4[s.uf] = 1'b0;
                            end
                            else if (s.pkts < mult)
                            begin
                                next_s.st = HID_ST_ISSUE;
                            end
                            else if (!(wr4 && reg_wdata[s.uf]))
                            begin
                                next_s.dw4[s.uf] = 1'b0;
                            end
                        end
                        HID_RES_ERR:
                        begin
                            // Zero counter means unlimited retries
                            if (s.dw3[HID_CERR_HI:HID_CERR_LO] != 2'h0)
                                next_s.dw3[HID_CERR_HI:HID_CERR_LO] =
                                    s.dw3[HID_CERR_HI:HID_CERR_LO] - 2'h1;
                            if (s.dw3[HID_CERR_HI:HID_CERR_LO] == 2'h1)
                            begin
                                next_s.dw3[HID_STOP_BIT] = 1'b1;
                                next_s.dw0[HID_ARMED_BIT] = 1'b0;
                                next_s.dw3[HID_RUN_BIT] = 1'b0;
                            end
                        end
                        HID_RES_STALL:
                        begin
                            // Stall is final, unlike errors; no retry count applies
                            next_s.dw3[HID_STOP_BIT] = 1'b1;
                            next_s.dw0[HID_ARMED_BIT] = 1'b0;
                            next_s.dw3[HID_RUN_BIT] = 1'b0;
                        end
                        default: next_s.st = HID_ST_IDLE;
                    endcase
                end
            end
            default: next_s.st = HID_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s.st <= HID_ST_IDLE;
            s.dw0 <= HID_WORD_RESET;
            s.dw1 <= HID_WORD_RESET;
            s.dw2 <= HID_WORD_RESET;
            s.dw3 <= HID_WORD_RESET;
            s.dw4 <= HID_WORD_RESET;
            s.pkts <= '0;
            s.uf <= '0;
            s.rdata <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    run_mirror_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(s.dw0[HID_ARMED_BIT]) && !$past(wr0) |-> !s.dw3[HID_RUN_BIT])
    else $error("run flag not cleared with armed flag");

    stall_halts_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.st == HID_ST_WAIT && res_valid && res_code == HID_RES_STALL
        |=> s.dw3[HID_STOP_BIT] && !s.dw0[HID_ARMED_BIT])
    else $error("stall did not halt descriptor");

    toggle_next_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.st == HID_ST_WAIT && res_valid && res_code == HID_RES_ACK && !wr3
        |=> s.dw3[HID_TOGGLE_BIT] != $past(s.dw3[HID_TOGGLE_BIT]))
    else $error("toggle not advanced after ack");

    error_count_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.st == HID_ST_WAIT && res_valid && res_code == HID_RES_ERR && !wr3
        && s.dw3[HID_CERR_HI:HID_CERR_LO] == 2'h2
        |=> s.dw3[HID_CERR_HI:HID_CERR_LO] == 2'h1 && !s.dw3[HID_STOP_BIT])
    else $error("error counter step wrong");

    byte_total_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.st == HID_ST_WAIT && res_valid && res_code == HID_RES_ACK && !wr3
        |=> s.dw3[HID_DONE_HI:HID_DONE_LO]
            == $past(s.dw3[HID_DONE_HI:HID_DONE_LO]) + $past(res_bytes))
    else $error("done count not accumulated");

    skip_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
        tok_valid |-> s.dw0[HID_ARMED_BIT] && !s.dw3[HID_STOP_BIT])
    else $error("token issued for inactive descriptor");

    mask_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.st == HID_ST_IDLE && sof_pulse && !s.dw4[uframe] |=> s.st == HID_ST_IDLE)
    else $error("issue started for unmasked microframe");

    mult_bound_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.st == HID_ST_WAIT && res_valid && res_code == HID_RES_ACK
        && s.pkts == mult |=> s.st == HID_ST_IDLE)
    else $error("more packets than multiplier allows");

    poll_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.dw2[HID_FSEL_HI:HID_FSEL_LO] == '0 && s.dw4[uframe] |-> due)
    else $error("zero selector missed a masked microframe");

    err_halt_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.st == HID_ST_WAIT && res_valid && res_code == HID_RES_ERR
        && s.dw3[HID_CERR_HI:HID_CERR_LO] == 2'h1
        |=> s.dw3[HID_STOP_BIT] && !s.dw0[HID_ARMED_BIT] && !s.dw3[HID_RUN_BIT])
    else $error("last allowed error did not halt");

    err_unlimited_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.st == HID_ST_WAIT && res_valid && res_code == HID_RES_ERR && !wr3
        && s.dw3[HID_CERR_HI:HID_CERR_LO] == 2'h0
        |=> !s.dw3[HID_STOP_BIT] && s.dw3[HID_CERR_HI:HID_CERR_LO] == 2'h0)
    else $error("zero error counter changed or halted");

    done_disarm_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.st == HID_ST_WAIT && res_valid && res_code == HID_RES_ACK && complete && !wr0
        |=> !s.dw0[HID_ARMED_BIT])
    else $error("armed flag kept after completion");

    mask_spent_a: assert property (@(posedge mclk) disable iff (sys_rst)
        s.st == HID_ST_WAIT && res_valid && res_code == HID_RES_ACK && !complete
        && s.pkts == mult && !wr4
        |=> !s.dw4[s.uf] && s.dw0[HID_ARMED_BIT])
    else $error("spent microframe not cleared");

endmodule

// >>> verilog/hid_pkg.sv
package hid_pkg;

    // Register byte addresses on the plain port
    localparam logic [7:0] HID_ADDR_DW0 = 8'h00;
    localparam logic [7:0] HID_ADDR_DW1 = 8'h04;
    localparam logic [7:0] HID_ADDR_DW2 = 8'h08;
    localparam logic [7:0] HID_ADDR_DW3 = 8'h0c;
    localparam logic [7:0] HID_ADDR_DW4 = 8'h10;
    localparam logic [7:0] HID_ADDR_STAT = 8'h14;

    // Writable bits per word; reserved bits store and read as zero
    localparam logic [31:0] HID_DW0_WMASK = 32'hffff_fff9;
    localparam logic [31:0] HID_DW1_WMASK = 32'h0000_7fff;
    localparam logic [31:0] HID_DW2_WMASK = 32'h00ff_ffff;
    localparam logic [31:0] HID_DW3_WMASK = 32'hc380_7fff;
    localparam logic [31:0] HID_DW4_WMASK = 32'h0000_00ff;
    localparam logic [31:0] HID_WORD_RESET = 32'h0000_0000;

    // Word 0 fields
    localparam int HID_ARMED_BIT = 0;
    localparam int HID_TOTAL_LO = 3;
    localparam int HID_TOTAL_HI = 17;
    localparam int HID_MAXPKT_LO = 18;
    localparam int HID_MAXPKT_HI = 28;
    localparam int HID_MULT_LO = 29;
    localparam int HID_MULT_HI = 30;
    localparam int HID_EP0_BIT = 31;

    // Word 1 fields
    localparam int HID_EPU_LO = 0;
    localparam int HID_EPU_HI = 2;
    localparam int HID_FADDR_LO = 3;
    localparam int HID_FADDR_HI = 9;
    localparam int HID_TOKEN_LO = 10;
    localparam int HID_TOKEN_HI = 11;
    localparam int HID_KIND_LO = 12;
    localparam int HID_KIND_HI = 13;
    localparam int HID_SPLIT_BIT = 14;

    // Word 2 fields
    localparam int HID_FSEL_LO = 3;
    localparam int HID_FSEL_HI = 7;
    localparam int HID_PTR_LO = 8;
    localparam int HID_PTR_HI = 23;

    // Word 3 fields
    localparam int HID_DONE_LO = 0;
    localparam int HID_DONE_HI = 14;
    localparam int HID_CERR_LO = 23;
    localparam int HID_CERR_HI = 24;
    localparam int HID_TOGGLE_BIT = 25;
    localparam int HID_STOP_BIT = 30;
    localparam int HID_RUN_BIT = 31;

    // Word 4 fields
    localparam int HID_MASK_LO = 0;
    localparam int HID_MASK_HI = 7;

    localparam logic [1:0] HID_KIND_INTR = 2'h3;
    localparam logic [1:0] HID_TOKEN_OUT = 2'h0;
    localparam logic [1:0] HID_TOKEN_IN = 2'h1;

    typedef enum logic [1:0] {
        HID_RES_ACK,
        HID_RES_ERR,
        HID_RES_STALL
    } hid_res_e;

    typedef enum logic [1:0] {
        HID_ST_IDLE,
        HID_ST_ISSUE,
        HID_ST_WAIT
    } hid_state_e;

endpackage

// >>> verilog/hid_poll_match.sv
`timescale 1ns/1ns
module hid_poll_match #(
    parameter int FSEL_W = 5
) (
    input wire logic [FSEL_W-1:0] frame_sel,
    input wire logic [FSEL_W-1:0] frame_num,
    input wire logic [7:0] schedule_mask,
    input wire logic [2:0] uframe,
    output logic due
);
    logic [FSEL_W-1:0] period_mask;
    logic frame_hit;

    // Period in ms is twice the top set bit of the selector, so the
    // compare covers every bit up to and including that top bit
    genvar i;
    generate
        for (i = 0; i < FSEL_W; i++)
        begin : g_pmask
            assign period_mask[i] = |frame_sel[FSEL_W-1:i];
        end
    endgenerate

    // Zero selector means every millisecond; the mask picks microframes
    assign frame_hit = ((frame_num ^ frame_sel) & period_mask) == '0;
    assign due = frame_hit && schedule_mask[uframe];
endmodule

// >>> test/hid_usb_func_model.sv
`timescale 1ns/1ns
module hid_usb_func_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic tok_valid,
    input wire hid_pkg::hid_res_e cfg_code,
    input wire logic [14:0] cfg_bytes,
    input wire logic [3:0] cfg_delay,
    output logic res_valid,
    output hid_pkg::hid_res_e res_code,
    output logic [14:0] res_bytes
);
    import hid_pkg::*;
    int left = -1;

    // Idle result lines drive STALL with bytes inverted each cycle, so a late sample shows
    always @(posedge mclk)
    begin
        res_valid <= 1'b0;
        res_code <= HID_RES_STALL;
        res_bytes <= sys_rst ? 15'h0000 : ~res_bytes;
        if (sys_rst)
            left <= -1;
        else if (left == 0)
        begin
            res_valid <= 1'b1;
            res_code <= cfg_code;
            res_bytes <= cfg_bytes;
            left <= -1;
        end
        else if (left > 0)
            left <= left - 1;
        else if (tok_valid === 1'b1)
            left <= int'(cfg_delay);
    end
endmodule

// >>> test/hs_interrupt_descriptor_decode_tb_top.sv
`timescale 1ns/1ns
module hs_interrupt_descriptor_decode_tb_top;
    import hid_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sof_pulse = 1'b0;
    logic tok_valid, tok_split, tok_toggle, res_valid;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [4:0] frame_num = 5'h00;
    logic [2:0] uframe = 3'h0;
    logic [1:0] tok_pid;
    logic [6:0] tok_faddr;
    logic [3:0] tok_endpoint;
    logic [3:0] cfg_delay = 4'h0;
    logic [15:0] tok_ptr;
    logic [10:0] tok_maxpkt;
    logic [14:0] res_bytes;
    logic [14:0] cfg_bytes = 15'h0000;
    hid_res_e res_code;
    hid_res_e cfg_code = HID_RES_ACK;
    int error_cnt = 0, cmp_count = 0, tok_cnt = 0, cyc = 0;

    hid_decode dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sof_pulse(sof_pulse),
        .frame_num(frame_num), .uframe(uframe), .tok_valid(tok_valid), .tok_pid(tok_pid),
        .tok_faddr(tok_faddr), .tok_endpoint(tok_endpoint), .tok_split(tok_split),
        .tok_ptr(tok_ptr), .tok_maxpkt(tok_maxpkt), .tok_toggle(tok_toggle),
        .res_valid(res_valid), .res_code(res_code), .res_bytes(res_bytes));
    hid_usb_func_model peer (.mclk(mclk), .sys_rst(sys_rst), .tok_valid(tok_valid),
        .cfg_code(cfg_code), .cfg_bytes(cfg_bytes), .cfg_delay(cfg_delay),
        .res_valid(res_valid), .res_code(res_code), .res_bytes(res_bytes));

    task automatic finish_test();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk(reg_rdata, exp, msg);
    endtask

    task automatic load(input logic [31:0] w0, w1, w2, w3, w4);
        wr(HID_ADDR_DW0, w0);
        wr(HID_ADDR_DW1, w1);
        wr(HID_ADDR_DW2, w2);
        wr(HID_ADDR_DW3, w3);
        wr(HID_ADDR_DW4, w4);
    endtask

    // One microframe start, far side answers as configured, then count tokens
    task automatic go(input logic [4:0] f, input logic [2:0] u, input hid_res_e c,
        input logic [14:0] n, input logic [3:0] d, input int exp_tok);
        int t0;
        t0 = tok_cnt;
        cfg_code <= c;
        cfg_bytes <= n;
        cfg_delay <= d;
        @(posedge mclk);
        frame_num <= f;
        uframe <= u;
        sof_pulse <= 1'b1;
        @(posedge mclk);
        sof_pulse <= 1'b0;
        repeat (40) @(posedge mclk);
        chk(32'(tok_cnt - t0), 32'(exp_tok), "token count");
    endtask

    task automatic t_fields();
        rd(HID_ADDR_DW3, 32'h0, "w3 reset");
        rd(HID_ADDR_STAT, 32'h0, "status reset");
        wr(HID_ADDR_DW1, 32'hffff_ffff);
        rd(HID_ADDR_DW1, HID_DW1_WMASK, "w1 reserved");
        chk(32'({tok_faddr, tok_split}), 32'h00ff, "faddr split");
        wr(HID_ADDR_DW3, 32'hffff_ffff);
        rd(HID_ADDR_DW3, HID_DW3_WMASK, "w3 reserved");
        wr(HID_ADDR_DW1, 32'h3555);
        wr(HID_ADDR_DW2, ((32'h1000 - 32'h400) >> 3 << 8) | 32'hff00_0000);
        rd(HID_ADDR_DW2, 32'h0001_8000, "w2 reserved");
        chk(32'(tok_ptr), 32'h0180, "pointer");
        chk(32'({tok_pid, tok_faddr, tok_endpoint[3:1], tok_split}), 32'h0aaa, "fields");
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h0, "unmapped");
    endtask

    task automatic t_ack();
        load(32'ha100_0201, 32'h3555, 32'h0, 32'h8180_0000, 32'h01);
        chk(32'(tok_endpoint), 32'hb, "endpoint");
        chk(32'({tok_maxpkt, tok_toggle}), 32'h080, "maxpkt toggle");
        go(5'h0, 3'h1, HID_RES_ACK, 15'd10, 4'h0, 0);
        go(5'h3, 3'h0, HID_RES_ACK, 15'd10, 4'h0, 1);
        chk(32'(tok_toggle), 32'h1, "toggle out");
        rd(HID_ADDR_DW3, 32'h0380_000a, "ack w3");
        rd(HID_ADDR_DW0, 32'ha100_0200, "ack w0");
        rd(HID_ADDR_DW4, 32'h0, "ack mask");
    endtask

    task automatic t_rates();
        for (int b = 5; b <= 9; b++)
        begin
            load(32'ha100_0201, 32'h3555, 32'(8 << (b - 5)), 32'h8180_0000, 32'h80);
            go(5'h0, 3'h7, HID_RES_ACK, 15'd1, 4'h0, 0);
            go(5'(1 << (b - 5)), 3'h7, HID_RES_ACK, 15'd1, 4'h0, 1);
        end
    endtask

    task automatic t_multi();
        load(32'h4020_0081, 32'h3155, 32'h0, 32'h8180_0000, 32'h04);
        go(5'h1, 3'h2, HID_RES_ACK, 15'd8, 4'h5, 2);
        chk(32'(tok_pid), 32'h0, "out token");
        rd(HID_ADDR_DW3, 32'h0180_0010, "multi w3");
        rd(HID_ADDR_DW0, 32'h4020_0080, "multi w0");
        rd(HID_ADDR_STAT, 32'h0000_0028, "multi status");
        load(32'h2020_0081, 32'h3155, 32'h0, 32'h8180_0000, 32'h04);
        go(5'h1, 3'h2, HID_RES_ACK, 15'd8, 4'h0, 1);
        rd(HID_ADDR_DW3, 32'h8380_0008, "spent w3");
        rd(HID_ADDR_DW0, 32'h2020_0081, "spent w0");
        rd(HID_ADDR_DW4, 32'h0, "spent mask");
        go(5'h1, 3'h2, HID_RES_ACK, 15'd8, 4'h0, 0);
    endtask

    task automatic t_halt(input hid_res_e c, input logic [1:0] ce, input logic [31:0] w3x,
        input logic [31:0] w0x);
        load(32'ha100_0201, 32'h3555, 32'h0, 32'h8000_0000 | 32'(ce) << 23, 32'h01);
        go(5'h0, 3'h0, c, 15'd0, 4'h2, 1);
        rd(HID_ADDR_DW3, w3x, "halt w3");
        rd(HID_ADDR_DW0, w0x, "halt w0");
        wr(HID_ADDR_DW0, 32'ha100_0201);
        wr(HID_ADDR_DW3, 32'hc000_0000);
        go(5'h0, 3'h0, HID_RES_ACK, 15'd1, 4'h0, 0);
        rd(HID_ADDR_DW3, 32'hc000_0000, "stopped w3");
    endtask

    initial
    begin
        forever #50 mclk = ~mclk;
    end

    // Ceiling is over ten times the expected run length
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (tok_valid === 1'b1)
            tok_cnt <= tok_cnt + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    initial
    begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        t_fields();
        t_ack();
        t_rates();
        t_multi();
        t_halt(HID_RES_ERR, 2'h2, 32'h8080_0000, 32'ha100_0201);
        t_halt(HID_RES_ERR, 2'h0, 32'h8000_0000, 32'ha100_0201);
        t_halt(HID_RES_ERR, 2'h1, 32'h4000_0000, 32'ha100_0200);
        t_halt(HID_RES_STALL, 2'h3, 32'h4180_0000, 32'ha100_0200);
        finish_test();
    end
endmodule
